// >>> hw/pfq_busport.sv
module pfq_busport import pfq_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        want_i,
	input  wire pfq_bus_type cmd_i,
	input  wire logic        ack_i,
	output pfq_bus_type      bus_o,
	output logic             req_o,
	output logic             done_o
);
	`include "pfq_regs.svh"

	// ----------------------------------------------------------------
	// Request held until acknowledged
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o <= 1'b0;
			bus_o <= '0;
		end else if (ce_i) begin
			if (!req_o && want_i) begin
				req_o <= 1'b1;
				bus_o <= cmd_i;
			end else if (req_o && ack_i) begin
				req_o <= 1'b0;
			end
		end
	end

	assign done_o = ce_i & req_o & ack_i;
endmodule

// >>> hw/pfq_pkg.sv
package pfq_pkg;

	// ----------------------------------------------------------------
	// Bus request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        iack;
	} pfq_bus_type;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_SSPH, S_SSPL, S_PCH, S_PCL, S_FILL0, S_FILL1, S_RUN, S_EXT, S_NEXT,
		S_PUSHL, S_PUSHH, S_IACK, S_PUSHSR, S_VECH, S_VECL
	} pfq_state_type;

endpackage

// >>> hw/pfq_prefetch.sv
// How it works
// - Two words queued, decoder word and next word, refetched alongside execution.
// - Execution start pulses only after opcode and following word are loaded.
// - Each extension word consumed triggers exactly one refill read.
// - Dropping the opcode for the next instruction issues its last stream read.
// - Branch discards both words and refills from the target; interrupt discards both.
// - Program counter equals address of the last stream word read.
// - Reset reads stack pointer at 0,2, counter at 4,6, then two words.
// - Interrupt pushes counter low, high, acknowledges, pushes status, reads vector, fills.
module pfq_prefetch import pfq_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        ext_use_i,
	input  wire logic        next_op_i,
	input  wire logic        branch_i,
	input  wire logic [31:0] target_i,
	input  wire logic        irq_take_i,
	input  wire logic [15:0] status_word_i,
	input  wire logic        ack_i,
	input  wire logic [15:0] rdata_i,
	output pfq_bus_type      bus_o,
	output logic             req_o,
	output logic [15:0]      ir_o,
	output logic [15:0]      ext_word_o,
	output logic             ext_valid_o,
	output logic             exec_start_o,
	output logic [31:0]      pc_o,
	output logic [31:0]      supervisor_stack_pointer_o,
	output logic             busy_o
);
	`include "pfq_regs.svh"

	pfq_state_type state_r, state_nxt;
	logic [15:0]   irc_r;
	logic [15:0]   hi_r;
	logic [15:0]   sr_r;
	logic [31:0]   vector_pointer_r;
	logic          want;
	logic          done;
	logic          acc;
	pfq_bus_type   cmd;

	function automatic logic [31:0] inc2(input logic [31:0] a);
		return a + `PFQ_WORD_STEP;
	endfunction

	function automatic logic [31:0] dec2(input logic [31:0] a);
		return a - `PFQ_WORD_STEP;
	endfunction

	assign acc = ce_i & (state_r == S_RUN);

	// ----------------------------------------------------------------
	// Bus command per state
	// ----------------------------------------------------------------
	always_comb begin
		cmd  = '0;
		want = 1'b1;
		unique case (state_r)
			S_SSPH:   cmd.addr = `PFQ_SSP_HI_ADDR;
			S_SSPL:   cmd.addr = `PFQ_SSP_LO_ADDR;
			S_PCH:    cmd.addr = `PFQ_PC_HI_ADDR;
			S_PCL:    cmd.addr = `PFQ_PC_LO_ADDR;
			S_FILL0:  cmd.addr = pc_o;
			S_FILL1, S_EXT, S_NEXT:
				cmd.addr = inc2(pc_o);
			S_RUN:    want = 1'b0;
			S_PUSHL: begin
				cmd.addr  = dec2(supervisor_stack_pointer_o);
				cmd.wdata = pc_o[15:0];
				cmd.wr    = 1'b1;
			end
			S_PUSHH: begin
				cmd.addr  = dec2(supervisor_stack_pointer_o);
				cmd.wdata = pc_o[31:16];
				cmd.wr    = 1'b1;
			end
			S_IACK: begin
				cmd.addr = `PFQ_IACK_ADDR;
				cmd.iack = 1'b1;
			end
			S_PUSHSR: begin
				cmd.addr  = dec2(supervisor_stack_pointer_o);
				cmd.wdata = sr_r;
				cmd.wr    = 1'b1;
			end
			S_VECH:   cmd.addr = vector_pointer_r;
			S_VECL:   cmd.addr = inc2(vector_pointer_r);
		endcase
	end

	pfq_busport u_port (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.want_i (want),
		.cmd_i  (cmd),
		.ack_i  (ack_i),
		.bus_o  (bus_o),
		.req_o  (req_o),
		.done_o (done)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_SSPH:   if (done) state_nxt = S_SSPL;
			S_SSPL:   if (done) state_nxt = S_PCH;
			S_PCH:    if (done) state_nxt = S_PCL;
			S_PCL:    if (done) state_nxt = S_FILL0;
			S_FILL0:  if (done) state_nxt = S_FILL1;
			S_FILL1, S_EXT, S_NEXT:
				if (done) state_nxt = S_RUN;
			S_RUN: begin
				if (ce_i && irq_take_i) state_nxt = S_PUSHL;
				else if (ce_i && branch_i) state_nxt = S_FILL0;
				else if (ce_i && next_op_i) state_nxt = S_NEXT;
				else if (ce_i && ext_use_i) state_nxt = S_EXT;
			end
			S_PUSHL:  if (done) state_nxt = S_PUSHH;
			S_PUSHH:  if (done) state_nxt = S_IACK;
			S_IACK:   if (done) state_nxt = S_PUSHSR;
			S_PUSHSR: if (done) state_nxt = S_VECH;
			S_VECH:   if (done) state_nxt = S_VECL;
			S_VECL:   if (done) state_nxt = S_FILL0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= S_SSPH;
			busy_o  <= 1'b1;
		end else if (ce_i) begin
			state_r <= state_nxt;
			busy_o  <= (state_nxt != S_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Prefetch queue
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_o       <= `PFQ_WORD_RST;
			irc_r      <= `PFQ_WORD_RST;
			ext_word_o <= `PFQ_WORD_RST;
		end else if (ce_i) begin
			if (done && state_r == S_FILL0) ir_o <= rdata_i;
			if (done && (state_r == S_FILL1 || state_r == S_EXT || state_r == S_NEXT))
				irc_r <= rdata_i;
			if (acc && !irq_take_i && !branch_i && next_op_i)
				ir_o <= irc_r;
			if (acc && !irq_take_i && !branch_i && !next_op_i && ext_use_i)
				ext_word_o <= irc_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_valid_o  <= 1'b0;
			exec_start_o <= 1'b0;
		end else if (ce_i) begin
			ext_valid_o  <= acc && !irq_take_i && !branch_i && !next_op_i && ext_use_i;
			exec_start_o <= done && (state_r == S_FILL1 || state_r == S_NEXT);
		end
	end

	// ----------------------------------------------------------------
	// Program counter, stack pointer, vector
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_o <= `PFQ_ADDR_RST;
			hi_r <= `PFQ_WORD_RST;
		end else if (ce_i) begin
			if (done && (state_r == S_PCH || state_r == S_VECH)) hi_r <= rdata_i;
			if (done && (state_r == S_PCL || state_r == S_VECL)) pc_o <= {hi_r, rdata_i};
			if (done && (state_r == S_FILL1 || state_r == S_EXT || state_r == S_NEXT))
				pc_o <= inc2(pc_o);
			if (acc && !irq_take_i && branch_i) pc_o <= target_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supervisor_stack_pointer_o <= `PFQ_ADDR_RST;
			sr_r                       <= `PFQ_WORD_RST;
			vector_pointer_r           <= `PFQ_ADDR_RST;
		end else if (ce_i) begin
			if (done && state_r == S_SSPH) supervisor_stack_pointer_o[31:16] <= rdata_i;
			if (done && state_r == S_SSPL) supervisor_stack_pointer_o[15:0] <= rdata_i;
			if (done && (state_r == S_PUSHL || state_r == S_PUSHH || state_r == S_PUSHSR))
				supervisor_stack_pointer_o <= dec2(supervisor_stack_pointer_o);
			if (acc && irq_take_i) sr_r <= status_word_i;
			if (done && state_r == S_IACK)
				vector_pointer_r <= {22'h0, rdata_i[7:0], 2'h0};
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_push_lo;
		done && state_r == S_PUSHL;
	endsequence

	sequence seq_push_hi;
		state_r == S_PUSHH && cmd.wdata == $past(pc_o[31:16]);
	endsequence

	AST_START_FULL: assert property (exec_start_o |-> state_r == S_RUN)
		else $error("execution start without full queue");
	AST_SSP_LO: assert property (req_o && state_r == S_SSPL |-> bus_o.addr == 32'h2)
		else $error("stack pointer low read at wrong address");
	AST_PC_LO: assert property (req_o && state_r == S_PCL |-> bus_o.addr == 32'h6)
		else $error("counter low read at wrong address");
	AST_EXT_REFILL: assert property (ext_valid_o |-> state_r == S_EXT)
		else $error("extension use without refill");
	AST_NEXT_SHIFT: assert property (acc && !irq_take_i && !branch_i && next_op_i
		|=> state_r == S_NEXT && ir_o == $past(irc_r))
		else $error("opcode drop did not shift queue");
	AST_BRANCH: assert property (acc && !irq_take_i && branch_i
		|=> state_r == S_FILL0 && pc_o == $past(target_i))
		else $error("branch did not restart fill");
	AST_IRQ_FLUSH: assert property (acc && irq_take_i |=> state_r == S_PUSHL)
		else $error("interrupt did not flush queue");
	AST_PC_STEP: assert property (done && state_r == S_EXT
		|=> pc_o == $past(pc_o) + 32'h2)
		else $error("counter did not step by two");
	AST_STREAM_ADDR: assert property (req_o && state_r == S_NEXT
		|-> bus_o.addr == pc_o + 32'h2)
		else $error("stream address not previous plus two");
	AST_INT_ORDER: assert property (seq_push_lo |=> seq_push_hi)
		else $error("interrupt push order wrong");
endmodule

// >>> hw/pfq_regs.svh
`ifndef PFQ_REGS_SVH
`define PFQ_REGS_SVH

// ----------------------------------------------------------------
// Start-up read addresses
// ----------------------------------------------------------------
`define PFQ_SSP_HI_ADDR 32'h0000_0000
`define PFQ_SSP_LO_ADDR 32'h0000_0002
`define PFQ_PC_HI_ADDR  32'h0000_0004
`define PFQ_PC_LO_ADDR  32'h0000_0006

// ----------------------------------------------------------------
// Address arithmetic
// ----------------------------------------------------------------
`define PFQ_WORD_STEP   32'h0000_0002
`define PFQ_IACK_ADDR   32'h0000_0000
`define PFQ_VEC_LSB     2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PFQ_ADDR_RST    32'h0000_0000
`define PFQ_WORD_RST    16'h0000

`endif

// >>> tb/pfq_mem_model.sv
module pfq_mem_model import pfq_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire pfq_bus_type bus_i,
	input  wire logic        req_i,
	output logic             ack_o,
	output logic [15:0]      rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] wait_r;

	// ----------------------------------------------------------------
	// Memory contents
	// ----------------------------------------------------------------
	function automatic logic [15:0] mem_word(input logic [31:0] a, input logic k);
		if (k)
			return 16'h0020;
		case (a)
			32'h0000_0002: return 16'h1000;
			32'h0000_0006: return 16'h0100;
			32'h0000_0082: return 16'h0200;
			default: return (a < 32'h0000_0100) ? 16'h0000 : (a[15:0] ^ 16'h5A5A);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Acknowledge, prompt or slow; data toggles when not valid
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		ack_o   <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			wait_r  <= 2'h0;
			rdata_o <= 16'hFFFF;
		end else if (req_i && !ack_o) begin
			if (wait_r == 2'h0) begin
				ack_o   <= 1'b1;
				rdata_o <= mem_word(bus_i.addr, bus_i.iack);
				wait_r  <= slow_i ? 2'h3 : 2'h0;
			end else begin
				wait_r <= wait_r - 2'h1;
			end
		end
	end
endmodule

// >>> tb/pfq_prefetch_tb.sv
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin fail_count++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

module pfq_prefetch_tb import pfq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_i, rst_i, ce_i, ext_use_i, next_op_i, branch_i, irq_take_i;
	logic        slow, ack, req, ext_valid, exec_start, busy, req_q;
	logic [31:0] target_i, pc, supervisor_stack_pointer, m_pc, m_ssp, rnd, t, vp;
	logic [15:0] status_word_i, rdata, ir, ext_word, m_ir, m_q1, v16, e16;
	pfq_bus_type bus;
	logic [49:0] bq[$];
	logic [15:0] eq[$];
	logic [79:0] xq[$];
	logic [49:0] e50;
	logic [79:0] e80;
	int          fail_count, cmp_count;

	pfq_prefetch i_pfq_prefetch (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.ext_use_i(ext_use_i), .next_op_i(next_op_i), .branch_i(branch_i),
		.target_i(target_i), .irq_take_i(irq_take_i), .status_word_i(status_word_i),
		.ack_i(ack), .rdata_i(rdata), .bus_o(bus), .req_o(req), .ir_o(ir),
		.ext_word_o(ext_word), .ext_valid_o(ext_valid), .exec_start_o(exec_start),
		.pc_o(pc), .supervisor_stack_pointer_o(supervisor_stack_pointer), .busy_o(busy));

	pfq_mem_model i_pfq_mem_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.bus_i(bus), .req_i(req), .ack_o(ack), .rdata_o(rdata));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [15:0] mw(input logic [31:0] a, input logic k);
		return i_pfq_mem_model.mem_word(a, k);
	endfunction
	task rd(input logic [31:0] a, input logic k);
		bq.push_back({a, 16'h0000, 1'b0, k});
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		bq.push_back({a, d, 1'b1, 1'b0});
	endtask
	task fill(input logic [31:0] a);
		rd(a, 1'b0);
		rd(a + 32'h2, 1'b0);
		m_ir = mw(a, 1'b0);
		m_q1 = mw(a + 32'h2, 1'b0);
		m_pc = a + 32'h2;
		xq.push_back({m_ir, m_pc, m_ssp});
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Command driver: 0 ext, 1 next, 2 branch, 3 irq, 4 branch+next, 5 irq+ext
	// ----------------------------------------------------------------
	task run_cmd(input int c);
		rnd = xs(rnd);
		t = 32'h0000_0400 + {23'h0, rnd[8:1], 1'b0};
		@(posedge clk_i);
		if (rnd[3]) begin
			ce_i      <= 1'b0;
			next_op_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			`CHK("freeze", {1'b0, m_ir}, {busy, ir})
			ce_i      <= 1'b1;
			next_op_i <= 1'b0;
			@(posedge clk_i);
		end
		ext_use_i     <= (c == 0) || (c == 5);
		next_op_i     <= (c == 1) || (c == 4);
		branch_i      <= (c == 2) || (c == 4);
		irq_take_i    <= (c == 3) || (c == 5);
		target_i      <= t;
		status_word_i <= rnd[31:16];
		slow          <= rnd[20];
		if (c < 2) begin
			if (c == 0)
				eq.push_back(m_q1);
			else
				m_ir = m_q1;
			rd(m_pc + 32'h2, 1'b0);
			m_pc = m_pc + 32'h2;
			m_q1 = mw(m_pc, 1'b0);
			if (c == 1)
				xq.push_back({m_ir, m_pc, m_ssp});
		end else if (c == 2 || c == 4) begin
			fill(t);
		end else begin
			wr(m_ssp - 32'h2, m_pc[15:0]);
			wr(m_ssp - 32'h4, m_pc[31:16]);
			rd(32'h0, 1'b1);
			wr(m_ssp - 32'h6, rnd[31:16]);
			m_ssp = m_ssp - 32'h6;
			v16 = mw(32'h0, 1'b1);
			vp = {22'h0, v16[7:0], 2'b00};
			rd(vp, 1'b0);
			rd(vp + 32'h2, 1'b0);
			fill({mw(vp, 1'b0), mw(vp + 32'h2, 1'b0)});
		end
		@(posedge clk_i);
		{ext_use_i, next_op_i, branch_i, irq_take_i} <= 4'h0;
		@(negedge clk_i);
		repeat (300) if (busy !== 1'b0) @(negedge clk_i);
		`CHK("idle", 1'b0, busy)
	endtask

	// ----------------------------------------------------------------
	// Output monitor
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		req_q <= req;
		if (!rst_i && req && !req_q) begin
			e50 = bq.size() ? bq.pop_front() : 50'h0;
			`CHK("bus", e50, {bus.addr, bus.wr ? bus.wdata : 16'h0000, bus.wr, bus.iack})
		end
		if (!rst_i && ext_valid) begin
			e16 = eq.size() ? eq.pop_front() : 16'h0;
			`CHK("ext", e16, ext_word)
		end
		if (!rst_i && exec_start) begin
			e80 = xq.size() ? xq.pop_front() : 80'h0;
			`CHK("exec", e80, {ir, pc, supervisor_stack_pointer})
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		repeat (30000) @(posedge clk_i);
		fail_count++;
		final_report;
	end

	initial begin
		{ce_i, rst_i, slow} = 3'h6;
		{ext_use_i, next_op_i, branch_i, irq_take_i} = 4'h0;
		target_i = 32'h0;
		status_word_i = 16'h0;
		rnd = 32'd53888;
		for (int a = 0; a < 8; a += 2)
			rd(a, 1'b0);
		m_ssp = {mw(32'h0, 1'b0), mw(32'h2, 1'b0)};
		fill({mw(32'h4, 1'b0), mw(32'h6, 1'b0)});
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		repeat (300) if (busy !== 1'b0) @(negedge clk_i);
		`CHK("boot", 1'b0, busy)
		for (int i = 0; i < 60; i++) begin
			rnd = xs(rnd);
			run_cmd(i < 6 ? i : int'(rnd % 6));
		end
		repeat (10) @(negedge clk_i);
		`CHK("left", 0, bq.size() + eq.size() + xq.size())
		final_report;
	end
endmodule
